/* sxe_pkg.sv */
/*
 * Package for the skip/subtract/table/xor/extended-add execution block.
 * Assumes a single 25 MHz instruction clock and synchronous inputs.
 */
package sxe_pkg;

    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 11;
    localparam int PROG_W     = 16;
    localparam int PADDR_W    = 13;
    localparam int TBH_W      = PADDR_W - DATA_W;

    localparam logic [DATA_W-1:0]  BYTE_ONES  = 8'hff;
    localparam logic [DATA_W-1:0]  BYTE_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0]  BYTE_ONE   = 8'h01;
    localparam logic [TBH_W-1:0]   LAST_PAGE  = 5'h1f;
    localparam logic [5:0]         FLAGS_RST  = 6'h00;

    // Flag vector positions
    localparam int FLG_CZ = 5;
    localparam int FLG_SC = 4;
    localparam int FLG_OV = 3;
    localparam int FLG_Z  = 2;
    localparam int FLG_AC = 1;
    localparam int FLG_C  = 0;

    typedef enum logic [4:0] {
        OP_NOP             = 5'h00,
        OP_SET_MEM         = 5'h01,
        OP_SET_BIT         = 5'h02,
        OP_INC_SKIP_ZERO   = 5'h03,
        OP_INC_ACC_SKIP_Z  = 5'h04,
        OP_SKIP_BIT_NZ     = 5'h05,
        OP_SKIP_IF_NONZERO = 5'h06,
        OP_SKIP_IF_ZERO    = 5'h07,
        OP_COPY_SKIP_ZERO  = 5'h08,
        OP_SKIP_BIT_Z      = 5'h09,
        OP_SUB_MEM         = 5'h0a,
        OP_SUBTRACT_TO_MEM = 5'h0b,
        OP_SUB_IMM         = 5'h0c,
        OP_SWAP_MEM        = 5'h0d,
        OP_SWAP_TO_ACC     = 5'h0e,
        OP_TABLE_READ_PAGE = 5'h0f,
        OP_TABLE_READ_LAST = 5'h10,
        OP_INC_TABLE_PAGE  = 5'h11,
        OP_INC_TABLE_LAST  = 5'h12,
        OP_XOR_MEM         = 5'h13,
        OP_XOR_TO_MEM      = 5'h14,
        OP_XOR_IMM         = 5'h15,
        OP_EXT_ADD_CARRY   = 5'h16,
        OP_EXT_ADD_CARRY_M = 5'h17,
        OP_EXT_ADD         = 5'h18,
        OP_EXT_ADD_TO_MEM  = 5'h19
    } sxe_op_t;

    typedef enum logic [2:0] {
        ST_EXEC  = 3'b001,
        ST_TABLE = 3'b010,
        ST_SKIP  = 3'b100
    } sxe_state_t;

    typedef struct packed {
        logic              valid;
        sxe_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [2:0]        bit_sel;
        logic [DATA_W-1:0] imm;
    } sxe_instr_t;

    typedef struct packed {
        logic [DATA_W:0]   sum;
        logic              aux;
        logic              ovf;
    } sxe_alu_t;

endpackage

/* sxe_alu.sv */
/*
 * Adder/subtractor with flag terms for the execution block.
 * Assumes operands are stable for the whole cycle.
 */
`timescale 1ns/1ps
module sxe_alu
    import sxe_pkg::*;
(
    // Operands
    input  wire logic [DATA_W-1:0] a_in,
    input  wire logic [DATA_W-1:0] b_in,
    input  wire logic              cin_in,
    input  wire logic              sub_in,
    // Result
    output sxe_alu_t               res_out
);

    logic [DATA_W-1:0] b_eff;
    logic [4:0]        low;

    // Subtract as a + ~b + 1, so carry out is the inverted borrow
    always_comb begin
        b_eff = sub_in ? ~b_in : b_in;
        low   = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_in};
        res_out.sum = {1'b0, a_in} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin_in};
        res_out.aux = low[4];
        res_out.ovf = (a_in[DATA_W-1] == b_eff[DATA_W-1]) &&
                      (res_out.sum[DATA_W-1] != a_in[DATA_W-1]);
    end

endmodule

/* sxe_tbl.sv */
/*
 * Table address former for program-memory table reads.
 * Assumes the pointers are held by the caller.
 */
`timescale 1ns/1ps
module sxe_tbl
    import sxe_pkg::*;
(
    // Pointers
    input  wire logic [DATA_W-1:0]  ptr_low_in,
    input  wire logic [TBH_W-1:0]   ptr_high_in,
    input  wire logic               last_page_in,
    input  wire logic               pre_inc_in,
    // Results
    output logic [DATA_W-1:0]       ptr_low_next_out,
    output logic [PADDR_W-1:0]      addr_out
);

    always_comb begin
        ptr_low_next_out = pre_inc_in ? ptr_low_in + BYTE_ONE : ptr_low_in;
        addr_out = {last_page_in ? LAST_PAGE : ptr_high_in, ptr_low_next_out};
    end

endmodule

/* sxe_exec.sv */
/*
 * Execution unit for set, skip, subtract, swap, table read, xor and
 * extended add instructions.
 * Assumes data memory reads are combinational (rd_data_in follows
 * mem_addr_out) and the program word is valid while prog_re_out is high.
 */
`timescale 1ns/1ps
module sxe_exec
    import sxe_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk_in,
    input  wire logic               sys_rst_in,
    // Decoded instruction
    input  sxe_instr_t              instr_in,
    // Data memory
    input  wire logic [DATA_W-1:0]  rd_data_in,
    output logic [ADDR_W-1:0]       mem_addr_out,
    output logic                    mem_we_out,
    output logic [ADDR_W-1:0]       mem_waddr_out,
    output logic [DATA_W-1:0]       mem_wdata_out,
    // Program memory table port
    output logic                    prog_re_out,
    output logic [PADDR_W-1:0]      prog_addr_out,
    input  wire logic [PROG_W-1:0]  prog_data_in,
    // Pipeline control
    output logic                    busy_out,
    output logic                    skip_out,
    // Architectural state
    output logic [DATA_W-1:0]       acc_out,
    output logic [5:0]              flags_out,
    output logic [DATA_W-1:0]       table_pointer_low_out,
    output logic [TBH_W-1:0]        table_pointer_high_out,
    output logic [DATA_W-1:0]       table_high_latch_out,
    // Pointer load from the rest of the core
    input  wire logic               tbp_we_in,
    input  wire logic [DATA_W-1:0]  tbp_low_in,
    input  wire logic [TBH_W-1:0]   tbp_high_in
);

    typedef struct packed {
        sxe_state_t         state;
        logic [DATA_W-1:0]  acc;
        logic [5:0]         flags;
        logic [DATA_W-1:0]  tbl_lo;
        logic [TBH_W-1:0]   tbl_hi;
        logic [DATA_W-1:0]  tbl_latch;
        logic [ADDR_W-1:0]  tbl_dst;
        logic               we;
        logic [ADDR_W-1:0]  waddr;
        logic [DATA_W-1:0]  wdata;
        logic               prog_re;
        logic [PADDR_W-1:0] prog_addr;
        logic               skip;
        logic               busy;
    } sxe_regs_t;

    sxe_regs_t r_q;
    sxe_regs_t r_d;

    sxe_alu_t          alu_res;
    logic [DATA_W-1:0] alu_a;
    logic [DATA_W-1:0] alu_b;
    logic              alu_cin;
    logic              alu_sub;
    logic              tbl_last;
    logic              tbl_inc;
    logic [DATA_W-1:0] tbl_lo_next;
    logic [PADDR_W-1:0] tbl_addr;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == BYTE_ZERO;
    endfunction

    function automatic logic [DATA_W-1:0] swap_nib(input logic [DATA_W-1:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    // Arithmetic flag update shared by subtract and add forms
    function automatic logic [5:0] arith_flags(input logic [5:0] f, input sxe_alu_t r,
                                                input logic with_cz);
        logic [5:0] n;
        n = f;
        n[FLG_C]  = r.sum[DATA_W];
        n[FLG_AC] = r.aux;
        n[FLG_OV] = r.ovf;
        n[FLG_Z]  = is_zero(r.sum[DATA_W-1:0]);
        n[FLG_SC] = r.ovf ^ r.sum[DATA_W-1];
        if (with_cz) begin
            n[FLG_CZ] = is_zero(r.sum[DATA_W-1:0]) & r.sum[DATA_W];
        end
        return n;
    endfunction

    sxe_alu u_alu (
        .a_in    (alu_a),
        .b_in    (alu_b),
        .cin_in  (alu_cin),
        .sub_in  (alu_sub),
        .res_out (alu_res)
    );

    sxe_tbl u_tbl (
        .ptr_low_in       (r_q.tbl_lo),
        .ptr_high_in      (r_q.tbl_hi),
        .last_page_in     (tbl_last),
        .pre_inc_in       (tbl_inc),
        .ptr_low_next_out (tbl_lo_next),
        .addr_out         (tbl_addr)
    );

    always_comb begin
        alu_a    = r_q.acc;
        alu_b    = (instr_in.op == OP_SUB_IMM) ? instr_in.imm : rd_data_in;
        alu_sub  = (instr_in.op == OP_SUB_MEM) || (instr_in.op == OP_SUBTRACT_TO_MEM) ||
                   (instr_in.op == OP_SUB_IMM);
        alu_cin  = alu_sub ? 1'b1 :
                   ((instr_in.op == OP_EXT_ADD_CARRY) || (instr_in.op == OP_EXT_ADD_CARRY_M)) ?
                   r_q.flags[FLG_C] : 1'b0;
        tbl_last = (instr_in.op == OP_TABLE_READ_LAST) || (instr_in.op == OP_INC_TABLE_LAST);
        tbl_inc  = (instr_in.op == OP_INC_TABLE_PAGE) || (instr_in.op == OP_INC_TABLE_LAST);
    end

    always_comb begin
        logic [DATA_W-1:0] inc_val;
        logic              bit_val;
        inc_val = rd_data_in + BYTE_ONE;
        bit_val = rd_data_in[instr_in.bit_sel];
        r_d = r_q;
        r_d.we      = 1'b0;
        r_d.prog_re = 1'b0;
        r_d.skip    = 1'b0;
        r_d.busy    = 1'b0;
        r_d.waddr   = instr_in.addr;
        if (tbp_we_in) begin
            r_d.tbl_lo = tbp_low_in;
            r_d.tbl_hi = tbp_high_in;
        end
        case (r_q.state)
            ST_EXEC: begin
                if (instr_in.valid) begin
                    case (instr_in.op)
                        OP_SET_MEM: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = BYTE_ONES;
                        end
                        OP_SET_BIT: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = rd_data_in | (BYTE_ONE << instr_in.bit_sel);
                        end
                        OP_INC_SKIP_ZERO: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = inc_val;
                            r_d.skip  = is_zero(inc_val);
                        end
                        OP_INC_ACC_SKIP_Z: begin
                            r_d.acc  = inc_val;
                            r_d.skip = is_zero(inc_val);
                        end
                        OP_SKIP_BIT_NZ:     r_d.skip = bit_val;
                        OP_SKIP_BIT_Z:      r_d.skip = !bit_val;
                        OP_SKIP_IF_NONZERO: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = rd_data_in;
                            r_d.skip  = !is_zero(rd_data_in);
                        end
                        OP_SKIP_IF_ZERO: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = rd_data_in;
                            r_d.skip  = is_zero(rd_data_in);
                        end
                        OP_COPY_SKIP_ZERO: begin
                            r_d.acc  = rd_data_in;
                            r_d.skip = is_zero(rd_data_in);
                        end
                        OP_SUB_MEM, OP_SUB_IMM: begin
                            r_d.acc   = alu_res.sum[DATA_W-1:0];
                            r_d.flags = arith_flags(r_q.flags, alu_res, 1'b1);
                        end
                        OP_SUBTRACT_TO_MEM: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = alu_res.sum[DATA_W-1:0];
                            r_d.flags = arith_flags(r_q.flags, alu_res, 1'b1);
                        end
                        OP_SWAP_MEM: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = swap_nib(rd_data_in);
                        end
                        OP_SWAP_TO_ACC: r_d.acc = swap_nib(rd_data_in);
                        OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST,
                        OP_INC_TABLE_PAGE, OP_INC_TABLE_LAST: begin
                            // For the increment forms the pointer moves before the address is formed
                            r_d.tbl_lo    = tbl_lo_next;
                            r_d.prog_re   = 1'b1;
                            r_d.prog_addr = tbl_addr;
                            r_d.tbl_dst   = instr_in.addr;
                            r_d.busy      = 1'b1;
                            r_d.state     = ST_TABLE;
                        end
                        OP_XOR_MEM, OP_XOR_IMM: begin
                            r_d.acc = r_q.acc ^ ((instr_in.op == OP_XOR_IMM) ? instr_in.imm : rd_data_in);
                            r_d.flags[FLG_Z] = is_zero(r_d.acc);
                        end
                        OP_XOR_TO_MEM: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = r_q.acc ^ rd_data_in;
                            r_d.flags[FLG_Z] = is_zero(r_d.wdata);
                        end
                        OP_EXT_ADD_CARRY, OP_EXT_ADD: begin
                            r_d.acc   = alu_res.sum[DATA_W-1:0];
                            r_d.flags = arith_flags(r_q.flags, alu_res, 1'b0);
                        end
                        OP_EXT_ADD_CARRY_M, OP_EXT_ADD_TO_MEM: begin
                            r_d.we    = 1'b1;
                            r_d.wdata = alu_res.sum[DATA_W-1:0];
                            r_d.flags = arith_flags(r_q.flags, alu_res, 1'b0);
                        end
                        default: ;
                    endcase
                    if (r_d.skip) begin
                        r_d.state = ST_SKIP;
                        r_d.busy  = 1'b1;
                    end
                end
            end
            ST_TABLE: begin
                r_d.we        = 1'b1;
                r_d.waddr     = r_q.tbl_dst;
                r_d.wdata     = prog_data_in[DATA_W-1:0];
                r_d.tbl_latch = prog_data_in[PROG_W-1:DATA_W];
                r_d.state     = ST_EXEC;
            end
            ST_SKIP: begin
                // Discarded instruction: no write, acc or flag update in this cycle; a tbp_we_in pointer load still lands
                r_d.state = ST_EXEC;
            end
            default: r_d.state = ST_EXEC;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r_q.state     <= ST_EXEC;
            r_q.acc       <= BYTE_ZERO;
            r_q.flags     <= FLAGS_RST;
            r_q.tbl_lo    <= BYTE_ZERO;
            r_q.tbl_hi    <= '0;
            r_q.tbl_latch <= BYTE_ZERO;
            r_q.tbl_dst   <= '0;
            r_q.we        <= 1'b0;
            r_q.waddr     <= '0;
            r_q.wdata     <= BYTE_ZERO;
            r_q.prog_re   <= 1'b0;
            r_q.prog_addr <= '0;
            r_q.skip      <= 1'b0;
            r_q.busy      <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign mem_addr_out           = instr_in.addr;
    assign mem_we_out             = r_q.we;
    assign mem_waddr_out          = r_q.waddr;
    assign mem_wdata_out          = r_q.wdata;
    assign prog_re_out            = r_q.prog_re;
    assign prog_addr_out          = r_q.prog_addr;
    assign busy_out               = r_q.busy;
    assign skip_out               = r_q.skip;
    assign acc_out                = r_q.acc;
    assign flags_out              = r_q.flags;
    assign table_pointer_low_out  = r_q.tbl_lo;
    assign table_pointer_high_out = r_q.tbl_hi;
    assign table_high_latch_out   = r_q.tbl_latch;

    a_skip_squash: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        r_q.skip |-> r_q.state == ST_SKIP ##1 (!r_q.we && $stable(r_q.acc) && $stable(r_q.flags)))
        else $error("skipped slot changed state");
    a_skip_two_cyc: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        r_q.skip |-> r_q.busy ##1 r_q.state == ST_EXEC)
        else $error("skip not two cycles");
    a_set_all_ones: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_SET_MEM) |=>
        (r_q.we && r_q.wdata == BYTE_ONES && $stable(r_q.flags)))
        else $error("set memory wrong");
    a_inc_skip: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_INC_SKIP_ZERO) |=>
        (r_q.skip == (r_q.wdata == BYTE_ZERO)))
        else $error("increment skip mismatch");
    a_sub_carry: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_SUB_MEM) |=>
        (r_q.flags[FLG_C] == ($past(r_q.acc) >= $past(rd_data_in))))
        else $error("subtract borrow wrong");
    a_sub_result: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_SUB_IMM) |=>
        (r_q.acc == DATA_W'($past(r_q.acc) - $past(instr_in.imm))))
        else $error("immediate subtract wrong");
    a_swap_acc: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_SWAP_TO_ACC) |=>
        (r_q.acc == {$past(rd_data_in[3:0]), $past(rd_data_in[7:4])} && !r_q.we))
        else $error("swap to acc wrong");
    a_table_latch: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        r_q.state == ST_TABLE |=> (r_q.we && r_q.tbl_latch == $past(prog_data_in[PROG_W-1:DATA_W])))
        else $error("table high latch wrong");
    a_last_page: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_TABLE_READ_LAST) |=>
        (r_q.prog_addr[PADDR_W-1:DATA_W] == LAST_PAGE))
        else $error("last page address wrong");
    a_xor_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (r_q.state == ST_EXEC && instr_in.valid && instr_in.op == OP_XOR_MEM) |=>
        (r_q.flags[FLG_Z] == (r_q.acc == BYTE_ZERO) && r_q.flags[FLG_C] == $past(r_q.flags[FLG_C])))
        else $error("xor flag wrong");

endmodule

/* tb_sxe_exec.sv */
/*
 * Self-checking bench for the execution unit: every opcode except OP_NOP from a row table, then the
 * discard of the slot after a taken skip, and reset. Stands in for data and program memory.
 */
`timescale 1ns/1ps
module tb_sxe_exec;
    import sxe_pkg::*;
    typedef struct packed {sxe_op_t op; logic [7:0] x; logic [7:0] m;} sxe_row_t;
    logic              sys_clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    sxe_instr_t        instr_in = '0;
    logic [7:0]        rd_data_in;
    logic [15:0]       prog_data_in, idle_word = 16'h0000;
    logic              tbp_we_in = 1'b0;
    logic [7:0]        tbp_low_in = 8'hfe;
    logic [4:0]        tbp_high_in = 5'h0a;
    logic [10:0]       mem_addr_out, mem_waddr_out;
    logic              mem_we_out, prog_re_out, busy_out, skip_out;
    logic [7:0]        mem_wdata_out, acc_out, table_pointer_low_out, table_high_latch_out;
    logic [12:0]       prog_addr_out;
    logic [5:0]        flags_out, e_flg;
    logic [4:0]        table_pointer_high_out, e_thi;
    logic [7:0]        dmem [2048];
    logic [7:0]        e_acc, e_mem, e_tlo, e_lat;
    logic              e_sk;
    int                error_cnt, n_compared, cyc;
    sxe_row_t          rows [34] = '{
        '{OP_COPY_SKIP_ZERO, 8'h00, 8'h9c}, '{OP_SET_MEM, 8'h00, 8'h12}, '{OP_SET_BIT, 8'h05, 8'h01},
        '{OP_INC_SKIP_ZERO, 8'h00, 8'hff}, '{OP_INC_SKIP_ZERO, 8'h00, 8'h7f},
        '{OP_INC_ACC_SKIP_Z, 8'h00, 8'hff}, '{OP_INC_ACC_SKIP_Z, 8'h00, 8'h41},
        '{OP_SKIP_BIT_NZ, 8'h07, 8'h80}, '{OP_SKIP_BIT_NZ, 8'h00, 8'hfe},
        '{OP_SKIP_IF_NONZERO, 8'h00, 8'h01}, '{OP_SKIP_IF_NONZERO, 8'h00, 8'h00},
        '{OP_SKIP_IF_ZERO, 8'h00, 8'h00}, '{OP_SKIP_IF_ZERO, 8'h00, 8'h10},
        '{OP_SKIP_BIT_Z, 8'h03, 8'hf7}, '{OP_SKIP_BIT_Z, 8'h03, 8'h08},
        '{OP_COPY_SKIP_ZERO, 8'h00, 8'h00}, '{OP_COPY_SKIP_ZERO, 8'h00, 8'h70},
        '{OP_SUB_MEM, 8'h00, 8'h90}, '{OP_SUBTRACT_TO_MEM, 8'h00, 8'he0}, '{OP_SUB_IMM, 8'h01, 8'h33},
        '{OP_SUB_IMM, 8'hdf, 8'h00}, '{OP_SWAP_MEM, 8'h00, 8'ha5}, '{OP_SWAP_TO_ACC, 8'h00, 8'h3c},
        '{OP_XOR_MEM, 8'h00, 8'hc3}, '{OP_XOR_TO_MEM, 8'h00, 8'h5a}, '{OP_XOR_IMM, 8'h81, 8'h00},
        '{OP_EXT_ADD, 8'h00, 8'h80}, '{OP_EXT_ADD_CARRY, 8'h00, 8'h0f},
        '{OP_EXT_ADD_CARRY_M, 8'h00, 8'h6f}, '{OP_EXT_ADD_TO_MEM, 8'h00, 8'h7f},
        '{OP_TABLE_READ_PAGE, 8'h00, 8'h00}, '{OP_INC_TABLE_PAGE, 8'h00, 8'h00},
        '{OP_INC_TABLE_LAST, 8'h00, 8'h00}, '{OP_TABLE_READ_LAST, 8'h00, 8'h00}};

    sxe_exec sxe_exec_inst (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instr_in(instr_in), .rd_data_in(rd_data_in),
        .mem_addr_out(mem_addr_out), .mem_we_out(mem_we_out), .mem_waddr_out(mem_waddr_out),
        .mem_wdata_out(mem_wdata_out), .prog_re_out(prog_re_out), .prog_addr_out(prog_addr_out),
        .prog_data_in(prog_data_in), .busy_out(busy_out), .skip_out(skip_out), .acc_out(acc_out),
        .flags_out(flags_out), .table_pointer_low_out(table_pointer_low_out),
        .table_pointer_high_out(table_pointer_high_out), .table_high_latch_out(table_high_latch_out),
        .tbp_we_in(tbp_we_in), .tbp_low_in(tbp_low_in), .tbp_high_in(tbp_high_in));

    // Program word pattern: low byte tracks the low pointer, high byte the page
    function automatic logic [15:0] pword(input logic [12:0] pa);
        return {3'h5, pa} ^ 16'h0069;
    endfunction

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    assign rd_data_in = dmem[mem_addr_out];
    // The unit latches the word in the cycle its read strobe is up
    assign prog_data_in = prog_re_out ? pword(prog_addr_out) : idle_word;
    always @(posedge sys_clk_in) begin
        if (mem_we_out)
            dmem[mem_waddr_out] <= mem_wdata_out;
        // Outside a read the word toggles so a late sample cannot pass
        idle_word <= ~idle_word;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    task automatic model(input sxe_op_t op, input logic [7:0] x, input logic [7:0] m);
        logic [8:0]  s;
        logic [4:0]  h;
        logic [7:0]  b;
        logic        ci;
        logic        ar;
        logic [15:0] w;
        ar = 1'b0;
        ci = 1'b0;
        b = m;
        e_mem = m;
        e_sk = 1'b0;
        case (op)
            OP_SET_MEM: e_mem = 8'hff;
            OP_SET_BIT: e_mem = m | (8'h01 << x[2:0]);
            OP_INC_SKIP_ZERO: e_mem = m + 8'h01;
            OP_INC_ACC_SKIP_Z: e_acc = m + 8'h01;
            OP_SKIP_BIT_NZ: e_sk = m[x[2:0]];
            OP_SKIP_BIT_Z: e_sk = !m[x[2:0]];
            OP_SKIP_IF_NONZERO: e_sk = (m != 8'h00);
            OP_SKIP_IF_ZERO: e_sk = (m == 8'h00);
            OP_COPY_SKIP_ZERO: e_acc = m;
            OP_SWAP_MEM: e_mem = {m[3:0], m[7:4]};
            OP_SWAP_TO_ACC: e_acc = {m[3:0], m[7:4]};
            OP_XOR_MEM, OP_XOR_IMM: e_acc = e_acc ^ ((op == OP_XOR_IMM) ? x : m);
            OP_XOR_TO_MEM: e_mem = e_acc ^ m;
            OP_SUB_MEM, OP_SUBTRACT_TO_MEM, OP_SUB_IMM: begin
                ar = 1'b1;
                ci = 1'b1;
                b = ~((op == OP_SUB_IMM) ? x : m);
            end
            OP_EXT_ADD_CARRY, OP_EXT_ADD_CARRY_M, OP_EXT_ADD, OP_EXT_ADD_TO_MEM: begin
                ar = 1'b1;
                ci = (op <= OP_EXT_ADD_CARRY_M) & e_flg[FLG_C];
            end
            OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST, OP_INC_TABLE_PAGE, OP_INC_TABLE_LAST: begin
                if (op >= OP_INC_TABLE_PAGE)
                    e_tlo = e_tlo + 8'h01;
                w = pword((op == OP_TABLE_READ_LAST || op == OP_INC_TABLE_LAST) ? {LAST_PAGE, e_tlo} : {e_thi, e_tlo});
                e_mem = w[7:0];
                e_lat = w[15:8];
            end
            default: ;
        endcase
        if (op == OP_INC_SKIP_ZERO)
            e_sk = (e_mem == 8'h00);
        if (op == OP_INC_ACC_SKIP_Z || op == OP_COPY_SKIP_ZERO)
            e_sk = (e_acc == 8'h00);
        if (op == OP_XOR_MEM || op == OP_XOR_IMM || op == OP_XOR_TO_MEM)
            e_flg[FLG_Z] = ((op == OP_XOR_TO_MEM) ? e_mem : e_acc) == 8'h00;
        if (ar) begin
            s = {1'b0, e_acc} + {1'b0, b} + {8'h00, ci};
            h = {1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            e_flg[FLG_OV] = (e_acc[7] == b[7]) && (s[7] != e_acc[7]);
            e_flg[FLG_C] = s[8];
            e_flg[FLG_AC] = h[4];
            e_flg[FLG_Z] = (s[7:0] == 8'h00);
            e_flg[FLG_SC] = e_flg[FLG_OV] ^ s[7];
            if (op <= OP_SUB_IMM)
                e_flg[FLG_CZ] = e_flg[FLG_Z] & e_flg[FLG_C];
            if (op == OP_SUBTRACT_TO_MEM || op == OP_EXT_ADD_CARRY_M || op == OP_EXT_ADD_TO_MEM)
                e_mem = s[7:0];
            else
                e_acc = s[7:0];
        end
    endtask

    // Presents one instruction; with sh set a store is offered in the slot that follows
    task automatic run(input sxe_op_t op, input logic [7:0] x, input logic [7:0] m, input logic [10:0] a,
                       input logic sh);
        int   nb;
        logic sk;
        nb = 0;
        sk = 1'b0;
        dmem[a] = m;
        model(op, x, m);
        instr_in = '{1'b1, op, a, x[2:0], x};
        @(posedge sys_clk_in);
        #1;
        for (int i = 0; i < 3; i++) begin
            sk = sk | skip_out;
            nb += int'(busy_out);
            instr_in = (sh && i == 0) ? sxe_instr_t'{1'b1, OP_SET_MEM, 11'h02b, 3'h0, 8'h00} : sxe_instr_t'(0);
            @(posedge sys_clk_in);
            #1;
        end
        chk(acc_out, e_acc, "acc");
        chk(flags_out, e_flg, "flags");
        chk(dmem[a], e_mem, "memory");
        chk(sk, e_sk, "skip");
        chk(nb, (e_sk || (op >= OP_TABLE_READ_PAGE && op <= OP_INC_TABLE_LAST)) ? 1 : 0, "busy");
        chk(table_high_latch_out, e_lat, "latch");
        chk(table_pointer_low_out, e_tlo, "low pointer");
    endtask

    task automatic chk_rst();
        e_acc = 8'h00;
        e_flg = FLAGS_RST;
        e_tlo = 8'h00;
        e_lat = 8'h00;
        chk(acc_out, e_acc, "acc after reset");
        chk(flags_out, e_flg, "flags after reset");
        chk(table_pointer_low_out, e_tlo, "low pointer after reset");
        chk(table_high_latch_out, e_lat, "latch after reset");
    endtask

    initial begin
        for (int i = 0; i < 2048; i++)
            dmem[i] = 8'h00;
        repeat (8) @(posedge sys_clk_in);
        #1;
        sys_rst_in = 1'b0;
        chk_rst();
        tbp_we_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        tbp_we_in = 1'b0;
        e_tlo = 8'hfe;
        e_thi = 5'h0a;
        chk(table_pointer_high_out, e_thi, "high pointer");
        for (int k = 0; k < 34; k++)
            run(rows[k].op, rows[k].x, rows[k].m, (rows[k].op >= OP_EXT_ADD_CARRY) ? 11'h7f3 : 11'h02a, 1'b0);
        dmem[11'h02b] = 8'h00;
        run(OP_SKIP_IF_ZERO, 8'h00, 8'h00, 11'h02a, 1'b1);
        chk(dmem[11'h02b], 8'h00, "store in skipped slot");
        run(OP_SKIP_IF_NONZERO, 8'h00, 8'h10, 11'h02a, 1'b0);
        sys_rst_in = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #1;
        sys_rst_in = 1'b0;
        chk_rst();
        print_verdict();
    end
endmodule
